/* File: core/urb_rx_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Complete flag high while unread data buffered
// - Clearing enable flushes buffer, flag drops
// - Interrupt requested while flag, enable and global enable set
// - Data register read pops oldest character
// - Error flags stored per entry with character
// - Status writes never alter error flags
// - Error flags raise no interrupt
// - Frame error reflects first stop bit
// - Only first stop bit is checked
// - Overrun: buffer full, waiting char, new start
// - Overrun remembered, shown after older reads
// - Successful transfer clears overrun flag
// - Parity checked only when enabled
// - Parity computed over data, mismatch stored
// - Parity error kept until character read
// - Disable is immediate, releases the pin
// - Read frees entry for immediate refill
// - Size seven selects nine-bit characters
// - Unused high data bits read zero
// - Shift to first stop, then buffer frame
module urb_rx_top
  import urb_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic RX_PIN_I,
  input wire logic GLOBAL_IRQ_EN_I,
  output logic RX_IRQ_O,
  output logic RX_PIN_OVERRIDE_O
);

  urb_top_state_t s_r;
  urb_top_state_t s_nxt;

  logic tick;
  logic flush;
  logic pop;
  logic push;
  logic fifo_full;
  logic buf_nonempty;
  logic start_seen;
  logic mismatch;
  logic [3:0] nbits;
  logic [7:0] status_val;
  logic [7:0] ctrl_b_val;
  logic [7:0] ctrl_c_val;
  logic [7:0] data_val;
  urb_entry_t head;
  urb_entry_t push_entry;
  logic [1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // Sample-rate divider and receive buffer

  urb_baud_div u_div (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .divisor_i(s_r.baud),
    .tick_o(tick)
  );

  // Two entries; a read and a refill may share one cycle
  urb_fifo2 u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .flush_i(flush),
    .push_i(push),
    .push_entry_i(push_entry),
    .pop_i(pop),
    .head_o(head),
    .count_o(count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Buffer control

  always_comb begin
    buf_nonempty = (count != 2'h0);
    fifo_full = (count == URB_FIFO_DEPTH);
    pop = REG_RD_I && (REG_ADDR_I == URB_ADDR_DATA);
    flush = !s_r.receiver_enable || (REG_WR_I && (REG_ADDR_I == URB_ADDR_CTRL_B) && !REG_WDATA_I[URB_CB_RECEIVER_ENABLE_BIT]);
    push = s_r.hold_valid && !flush && (!fifo_full || pop);
    push_entry = s_r.hold;
    // overrun shown with next stored char
    push_entry.dor = s_r.ovr_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read values

  always_comb begin
    status_val = 8'h00;
    ctrl_b_val = 8'h00;
    ctrl_c_val = 8'h00;
    data_val = 8'h00;
    status_val[URB_ST_RXC_BIT] = buf_nonempty;
    if (buf_nonempty) begin
      status_val[URB_ST_FE_BIT] = head.fe;
      status_val[URB_ST_DOR_BIT] = head.dor;
      status_val[URB_ST_UPE_BIT] = head.pe && s_r.par_en;
      ctrl_b_val[URB_CB_NINTH_RECEIVED_BIT_BIT] = head.data[8];
      data_val = head.data[7:0];
    end
    ctrl_b_val[URB_CB_RX_COMPLETE_IRQ_ENABLE_BIT] = s_r.rx_complete_irq_enable;
    ctrl_b_val[URB_CB_RECEIVER_ENABLE_BIT] = s_r.receiver_enable;
    ctrl_b_val[URB_CB_SIZE2_BIT] = s_r.size[2];
    ctrl_c_val[URB_CC_PAREN_BIT] = s_r.par_en;
    ctrl_c_val[URB_CC_PARODD_BIT] = s_r.par_odd;
    ctrl_c_val[URB_CC_STOP2_BIT] = s_r.stop2;
    ctrl_c_val[URB_CC_SIZE1_BIT] = s_r.size[1];
    ctrl_c_val[URB_CC_SIZE0_BIT] = s_r.size[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    nbits = urb_nbits(s_r.size);
    start_seen = 1'b0;
    mismatch = ((^s_r.shift) ^ s_r.pbit) != s_r.par_odd;

    // First flop feeds only the second
    s_nxt.pin_meta = RX_PIN_I;
    s_nxt.pin_sync = s_r.pin_meta;

    // Register writes; status writes are dropped
    if (REG_WR_I) begin
      if (REG_ADDR_I == URB_ADDR_STATUS) begin
        s_nxt.rdata = s_r.rdata;
      end else if (REG_ADDR_I == URB_ADDR_CTRL_B) begin
        s_nxt.rx_complete_irq_enable = REG_WDATA_I[URB_CB_RX_COMPLETE_IRQ_ENABLE_BIT];
        s_nxt.receiver_enable = REG_WDATA_I[URB_CB_RECEIVER_ENABLE_BIT];
        s_nxt.size[2] = REG_WDATA_I[URB_CB_SIZE2_BIT];
      end else if (REG_ADDR_I == URB_ADDR_CTRL_C) begin
        s_nxt.par_en = REG_WDATA_I[URB_CC_PAREN_BIT];
        s_nxt.par_odd = REG_WDATA_I[URB_CC_PARODD_BIT];
        s_nxt.stop2 = REG_WDATA_I[URB_CC_STOP2_BIT];
        s_nxt.size[1] = REG_WDATA_I[URB_CC_SIZE1_BIT];
        s_nxt.size[0] = REG_WDATA_I[URB_CC_SIZE0_BIT];
      end else if (REG_ADDR_I == URB_ADDR_BAUD) begin
        s_nxt.baud = REG_WDATA_I;
      end
    end

    // Read data valid only in the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (REG_RD_I) begin
      if (REG_ADDR_I == URB_ADDR_STATUS) begin
        s_nxt.rdata = status_val;
      end else if (REG_ADDR_I == URB_ADDR_CTRL_B) begin
        s_nxt.rdata = ctrl_b_val;
      end else if (REG_ADDR_I == URB_ADDR_CTRL_C) begin
        s_nxt.rdata = ctrl_c_val;
      end else if (REG_ADDR_I == URB_ADDR_DATA) begin
        s_nxt.rdata = data_val;
      end else if (REG_ADDR_I == URB_ADDR_BAUD) begin
        s_nxt.rdata = s_r.baud;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    // Frame receiver
    if (!s_r.receiver_enable) begin
      s_nxt.st = URB_RX_IDLE;
      s_nxt.tcnt = 4'h0;
      s_nxt.bcnt = 4'h0;
    end else if (tick) begin
      s_nxt.tcnt = s_r.tcnt + 4'h1;
      case (s_r.st)
        URB_RX_IDLE: begin
          // One sample per tick and no vote, so a glitch can begin a start check
          s_nxt.tcnt = 4'h0;
          if (!s_r.pin_sync) begin
            s_nxt.st = URB_RX_START;
          end
        end
        URB_RX_START: begin
          // Confirm the start bit half a bit later; glitches return to idle
          if (s_r.tcnt == URB_START_CHECK) begin
            if (s_r.pin_sync) begin
              s_nxt.st = URB_RX_IDLE;
            end else begin
              s_nxt.st = URB_RX_DATA;
              s_nxt.tcnt = 4'h0;
              s_nxt.bcnt = 4'h0;
              s_nxt.shift = 9'h000;
              start_seen = 1'b1;
            end
          end
        end
        URB_RX_DATA: begin
          if (s_r.tcnt == URB_BIT_LAST) begin
            s_nxt.shift[s_r.bcnt] = s_r.pin_sync;
            s_nxt.bcnt = s_r.bcnt + 4'h1;
            if (s_r.bcnt == nbits - 4'h1) begin
              s_nxt.st = s_r.par_en ? URB_RX_PARITY : URB_RX_STOP;
            end
          end
        end
        URB_RX_PARITY: begin
          if (s_r.tcnt == URB_BIT_LAST) begin
            s_nxt.pbit = s_r.pin_sync;
            s_nxt.st = URB_RX_STOP;
          end
        end
        URB_RX_STOP: begin
          if (s_r.tcnt == URB_BIT_LAST) begin
            // later stop bits never looked at
            s_nxt.st = URB_RX_IDLE;
          end
        end
        default: begin
          s_nxt.st = URB_RX_IDLE;
        end
      endcase
    end

    // Buffered character leaves the holding register
    if (push) begin
      s_nxt.hold_valid = 1'b0;
      s_nxt.ovr_pending = 1'b0;
    end

    if (start_seen && s_r.hold_valid && fifo_full && !pop) begin
      s_nxt.hold_valid = 1'b0;
      s_nxt.ovr_pending = 1'b1;
    end

    // Completed frame is captured after the clear so a new one wins
    if (s_r.receiver_enable && tick && (s_r.st == URB_RX_STOP) && (s_r.tcnt == URB_BIT_LAST)) begin
      s_nxt.hold_valid = 1'b1;
      s_nxt.hold.data = s_r.shift;
      s_nxt.hold.fe = !s_r.pin_sync;
      s_nxt.hold.pe = s_r.par_en && mismatch;
      s_nxt.hold.dor = 1'b0;
    end

    if (flush) begin
      s_nxt.hold_valid = 1'b0;
      s_nxt.ovr_pending = 1'b0;
    end

    // Registered, so the request follows the flag one cycle late
    // only the complete flag requests
    s_nxt.irq = s_r.rx_complete_irq_enable && buf_nonempty && GLOBAL_IRQ_EN_I && !flush;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.pin_meta <= 1'b1;
      s_r.pin_sync <= 1'b1;
      s_r.size <= URB_SIZE_RST;
      s_r.baud <= URB_BAUD_RST;
      s_r.st <= URB_RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA_O = s_r.rdata;
  assign RX_IRQ_O = s_r.irq;
  // Released at once on disable; an unfinished frame is not completed first
  // pin override follows enable
  assign RX_PIN_OVERRIDE_O = s_r.receiver_enable;

endmodule
`default_nettype wire

/* File: core/urb_pkg.sv */
package urb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [2:0] URB_ADDR_STATUS = 3'h0;
  localparam logic [2:0] URB_ADDR_CTRL_B = 3'h1;
  localparam logic [2:0] URB_ADDR_CTRL_C = 3'h2;
  localparam logic [2:0] URB_ADDR_DATA = 3'h3;
  localparam logic [2:0] URB_ADDR_BAUD = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int URB_ST_RXC_BIT = 7;
  localparam int URB_ST_FE_BIT = 4;
  localparam int URB_ST_DOR_BIT = 3;
  localparam int URB_ST_UPE_BIT = 2;
  localparam int URB_CB_RX_COMPLETE_IRQ_ENABLE_BIT = 7;
  localparam int URB_CB_RECEIVER_ENABLE_BIT = 4;
  localparam int URB_CB_SIZE2_BIT = 2;
  localparam int URB_CB_NINTH_RECEIVED_BIT_BIT = 1;
  localparam int URB_CC_PAREN_BIT = 5;
  localparam int URB_CC_PARODD_BIT = 4;
  localparam int URB_CC_STOP2_BIT = 3;
  localparam int URB_CC_SIZE1_BIT = 2;
  localparam int URB_CC_SIZE0_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and counts
  localparam logic [2:0] URB_SIZE_RST = 3'h3;
  localparam logic [2:0] URB_SIZE_NINE = 3'h7;
  localparam logic [7:0] URB_BAUD_RST = 8'h00;
  localparam logic [1:0] URB_FIFO_DEPTH = 2'h2;
  localparam logic [3:0] URB_START_CHECK = 4'h7;
  localparam logic [3:0] URB_BIT_LAST = 4'hf;

  typedef enum logic [2:0] {
    URB_RX_IDLE = 3'b000,
    URB_RX_START = 3'b001,
    URB_RX_DATA = 3'b010,
    URB_RX_PARITY = 3'b011,
    URB_RX_STOP = 3'b100
  } urb_rx_state_t;

  typedef struct packed {
    logic dor;
    logic fe;
    logic pe;
    logic [8:0] data;
  } urb_entry_t;

  typedef struct packed {
    logic [1:0] count;
    logic rd;
    logic wr;
    urb_entry_t [1:0] mem;
  } urb_fifo_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } urb_div_state_t;

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic rx_complete_irq_enable;
    logic receiver_enable;
    logic [2:0] size;
    logic par_en;
    logic par_odd;
    logic stop2;
    logic [7:0] baud;
    urb_rx_state_t st;
    logic [3:0] tcnt;
    logic [3:0] bcnt;
    logic [8:0] shift;
    logic pbit;
    logic hold_valid;
    urb_entry_t hold;
    logic ovr_pending;
    logic [7:0] rdata;
    logic irq;
  } urb_top_state_t;

  // Data bits per frame; reserved size codes fall back to eight
  function automatic logic [3:0] urb_nbits(input logic [2:0] size);
    logic [3:0] n;
    n = 4'h8;
    if (size == URB_SIZE_NINE) begin
      n = 4'h9;
    end else if (size < 3'h4) begin
      n = {2'b00, size[1:0]} + 4'h5;
    end
    return n;
  endfunction

endpackage

/* File: core/urb_baud_div.sv */
`timescale 1ns/100ps
`default_nettype none
module urb_baud_div
  import urb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] divisor_i,
  output logic tick_o
);

  urb_div_state_t s_r;
  urb_div_state_t s_nxt;

  // One tick every divisor+1 cycles, sixteen ticks per bit
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.cnt >= divisor_i) begin
      s_nxt.cnt = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule
`default_nettype wire

/* File: core/urb_fifo2.sv */
`timescale 1ns/100ps
`default_nettype none
module urb_fifo2
  import urb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire urb_entry_t push_entry_i,
  input wire logic pop_i,
  output urb_entry_t head_o,
  output logic [1:0] count_o
);

  urb_fifo_state_t s_r;
  urb_fifo_state_t s_nxt;
  logic do_pop;
  logic do_push;

  always_comb begin
    s_nxt = s_r;
    do_pop = pop_i && (s_r.count != 2'h0);
    // A freed entry may be refilled in the same cycle
    do_push = push_i && ((s_r.count != URB_FIFO_DEPTH) || do_pop);
    if (flush_i) begin
      s_nxt.count = 2'h0;
      s_nxt.rd = 1'b0;
      s_nxt.wr = 1'b0;
    end else begin
      if (do_push) begin
        s_nxt.mem[s_r.wr] = push_entry_i;
        s_nxt.wr = ~s_r.wr;
      end
      if (do_pop) begin
        s_nxt.rd = ~s_r.rd;
      end
      if (do_push && !do_pop) begin
        s_nxt.count = s_r.count + 2'h1;
      end else if (do_pop && !do_push) begin
        s_nxt.count = s_r.count - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign head_o = s_r.mem[s_r.rd];
  assign count_o = s_r.count;

endmodule
`default_nettype wire

/* File: tb/urb_rx_props.sv */
`timescale 1ns/100ps
`default_nettype none
module urb_rx_props
  import urb_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic RX_PIN_I,
  input wire logic GLOBAL_IRQ_EN_I,
  input wire logic RX_IRQ_O,
  input wire logic RX_PIN_OVERRIDE_O
);
  // Shadow of the control bits, taken on the same edge as the block's copy
  logic irq_on_r, rx_on_r, par_on_r;
  logic [2:0] size_r;
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      irq_on_r <= 1'b0;
      rx_on_r <= 1'b0;
      par_on_r <= 1'b0;
      size_r <= URB_SIZE_RST;
    end else if (REG_WR_I && REG_ADDR_I == URB_ADDR_CTRL_B) begin
      irq_on_r <= REG_WDATA_I[URB_CB_RX_COMPLETE_IRQ_ENABLE_BIT];
      rx_on_r <= REG_WDATA_I[URB_CB_RECEIVER_ENABLE_BIT];
      size_r[2] <= REG_WDATA_I[URB_CB_SIZE2_BIT];
    end else if (REG_WR_I && REG_ADDR_I == URB_ADDR_CTRL_C) begin
      par_on_r <= REG_WDATA_I[URB_CC_PAREN_BIT];
      size_r[1:0] <= REG_WDATA_I[URB_CC_SIZE1_BIT:URB_CC_SIZE0_BIT];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  a_irq_needs_global: assert property (!GLOBAL_IRQ_EN_I |=> !RX_IRQ_O)
    else $error("irq with global enable low");
  a_irq_needs_enable: assert property (!irq_on_r |=> !RX_IRQ_O)
    else $error("irq with irq enable low");
  a_irq_tracks_flag: assert property ($past(REG_RD_I && REG_ADDR_I == URB_ADDR_STATUS) |->
    RX_IRQ_O == (REG_RDATA_O[URB_ST_RXC_BIT] && $past(irq_on_r && GLOBAL_IRQ_EN_I)))
    else $error("irq disagrees with complete flag");
  a_off_reads_empty: assert property (REG_RD_I && REG_ADDR_I == URB_ADDR_STATUS && !rx_on_r |=>
    !REG_RDATA_O[URB_ST_RXC_BIT]) else $error("complete flag set while off");
  a_flush_drops_irq: assert property (REG_WR_I && REG_ADDR_I == URB_ADDR_CTRL_B &&
    !REG_WDATA_I[URB_CB_RECEIVER_ENABLE_BIT] |=> ##1 !RX_IRQ_O) else $error("irq kept after flush");
  a_pin_follows_on: assert property ($past(rx_on_r, 2) == rx_on_r && $past(rx_on_r) == rx_on_r |->
    RX_PIN_OVERRIDE_O == rx_on_r) else $error("pin override wrong");
  a_parity_off_zero: assert property (REG_RD_I && REG_ADDR_I == URB_ADDR_STATUS && !par_on_r |=>
    !REG_RDATA_O[URB_ST_UPE_BIT]) else $error("parity error with check off");
  a_high_bits_zero: assert property (REG_RD_I && REG_ADDR_I == URB_ADDR_DATA && size_r < 3'h3 |=>
    (REG_RDATA_O >> ($past(size_r[1:0]) + 3'h5)) == 8'h00) else $error("unused data bits set");
endmodule
bind urb_rx_top urb_rx_props u_props (.SYS_CLK_I, .RESET_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
  .REG_RD_I, .REG_RDATA_O, .RX_PIN_I, .GLOBAL_IRQ_EN_I, .RX_IRQ_O, .RX_PIN_OVERRIDE_O);
`default_nettype wire

/* File: tb/urb_serial_src.sv */
`timescale 1ns/100ps
`default_nettype none
module urb_serial_src (
  input wire logic clk_i,
  output logic line_o
);
  // Sixteen clocks a bit matches a divisor of zero
  localparam int BIT_CLKS = 16;
  initial line_o = 1'b1;
  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask
  // Ends on one idle bit so the line is high again before the next call, even after a low stop bit
  task automatic send(input logic [8:0] d, input int n, input logic pon, input logic pv, input logic stp);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) begin
      bit_out(d[i]);
    end
    if (pon) begin
      bit_out(pv);
    end
    bit_out(stp);
    bit_out(1'b1);
  endtask
endmodule
`default_nettype wire

/* File: tb/urb_rx_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module urb_rx_tb_top
  import urb_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gie = 1'b0;
  logic [7:0] rdata;
  logic pin, irq, ovr;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  urb_rx_top uut (.SYS_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .RX_PIN_I(pin), .GLOBAL_IRQ_EN_I(gie), .RX_IRQ_O(irq),
    .RX_PIN_OVERRIDE_O(ovr));
  urb_serial_src u_src (.clk_i(clk), .line_o(pin));
  always #4 clk = ~clk;
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The sequence needs some 2400 cycles; a hang stops well past that
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask
  // Parity worked out here so that a wrong one can be sent on purpose
  task automatic frame(input logic [8:0] d, input int n, input logic pon, input logic odd, input logic bad,
    input logic stp);
    u_src.send(d, n, pon, ^(d & ((9'h001 << n) - 9'h001)) ^ odd ^ bad, stp);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(URB_ADDR_CTRL_B, 8'h00, "ctrl_b reset"); // off
    rd_chk(URB_ADDR_CTRL_C, 8'h06, "ctrl_c reset"); // off
    rd_chk(URB_ADDR_BAUD, URB_BAUD_RST, "baud reset"); // rate
    rd_chk(URB_ADDR_STATUS, 8'h00, "status reset"); // empty
    wr_reg(3'h6, 8'hff);
    rd_chk(3'h6, 8'h00, "unmapped"); // ignored
  endtask
  task automatic t_basic();
    @(posedge clk);
    gie <= 1'b1;
    wr_reg(URB_ADDR_CTRL_B, 8'h90);
    frame(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    check("irq on", irq, 9'h001); // request
    rd_chk(URB_ADDR_STATUS, 8'h80, "status full"); // flag
    rd_chk(URB_ADDR_DATA, 8'ha5, "data"); // frame
    rd_chk(URB_ADDR_STATUS, 8'h00, "status empty"); // pop
    check("irq off", irq, 9'h000); // cleared
    @(posedge clk);
    gie <= 1'b0;
    frame(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    check("irq masked", irq, 9'h000); // global
    rd_chk(URB_ADDR_DATA, 8'h5a, "data masked"); // pop
  endtask
  task automatic t_overrun();
    for (int i = 1; i < 5; i++) begin
      frame(9'(8'h11 * i), 8, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    rd_chk(URB_ADDR_STATUS, 8'h80, "first status"); // hidden
    rd_chk(URB_ADDR_DATA, 8'h11, "first"); // refill
    rd_chk(URB_ADDR_STATUS, 8'h80, "second status"); // hidden
    rd_chk(URB_ADDR_DATA, 8'h22, "second"); // lost
    rd_chk(URB_ADDR_STATUS, 8'h88, "overrun status"); // shown
    rd_chk(URB_ADDR_DATA, 8'h44, "fourth"); // transfer
    rd_chk(URB_ADDR_STATUS, 8'h00, "drained"); // empty
  endtask
  task automatic t_errors();
    // Two stop bits selected; the sender still gives one and only the first counts
    wr_reg(URB_ADDR_CTRL_C, 8'h2e);
    rd_chk(URB_ADDR_CTRL_C, 8'h2e, "ctrl_c stored"); // select
    frame(9'h03c, 8, 1'b1, 1'b0, 1'b1, 1'b1);
    frame(9'h001, 8, 1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(URB_ADDR_STATUS, 8'h84, "parity bad"); // mismatch
    // Error bit positions always written as zero; set flags must survive it
    wr_reg(URB_ADDR_STATUS, 8'h00); // zeros
    rd_chk(URB_ADDR_STATUS, 8'h84, "after write"); // unchanged
    wr_reg(URB_ADDR_CTRL_C, 8'h06);
    rd_chk(URB_ADDR_STATUS, 8'h80, "check off"); // zero
    wr_reg(URB_ADDR_CTRL_C, 8'h36);
    rd_chk(URB_ADDR_STATUS, 8'h84, "kept"); // until read
    rd_chk(URB_ADDR_DATA, 8'h3c, "bad parity data"); // paired
    rd_chk(URB_ADDR_STATUS, 8'h90, "stop low"); // frame
    rd_chk(URB_ADDR_DATA, 8'h01, "stop low data"); // paired
    frame(9'h007, 8, 1'b1, 1'b1, 1'b0, 1'b1);
    rd_chk(URB_ADDR_STATUS, 8'h80, "odd good"); // odd
    rd_chk(URB_ADDR_DATA, 8'h07, "odd data"); // data
    wr_reg(URB_ADDR_CTRL_C, 8'h06);
  endtask
  task automatic t_sizes();
    wr_reg(URB_ADDR_CTRL_B, 8'h94);
    frame(9'h1a5, 9, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(URB_ADDR_STATUS, 8'h80, "nine status"); // order
    rd_chk(URB_ADDR_CTRL_B, 8'h96, "ninth bit"); // ninth
    rd_chk(URB_ADDR_DATA, 8'ha5, "nine low"); // low
    wr_reg(URB_ADDR_CTRL_B, 8'h90);
    wr_reg(URB_ADDR_CTRL_C, 8'h00);
    frame(9'h1f5, 5, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(URB_ADDR_DATA, 8'h15, "five bits"); // masked
    wr_reg(URB_ADDR_CTRL_C, 8'h06);
  endtask
  task automatic t_disable();
    frame(9'h0c3, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    fork
      frame(9'h0ff, 8, 1'b0, 1'b0, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge clk);
        wr_reg(URB_ADDR_CTRL_B, 8'h80);
        repeat (2) @(posedge clk);
        check("pin released", ovr, 9'h000); // release
        wr_reg(URB_ADDR_CTRL_B, 8'h90);
      end
    join
    rd_chk(URB_ADDR_STATUS, 8'h00, "flushed"); // flush
    check("pin owned", ovr, 9'h001); // owned
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_basic();
    t_overrun();
    t_errors();
    t_sizes();
    t_disable();
    give_verdict();
  end
endmodule
`default_nettype wire
